// ==== include/arx_defs.svh ====
// Constants for the asynchronous receive recovery block.
// Included by bare name from the design file.
`ifndef ARX_DEFS_SVH
`define ARX_DEFS_SVH
`define ARX_SPB_NORMAL 5'h10
`define ARX_SPB_DOUBLE 5'h08
`define ARX_VOTE_A_NORMAL 5'h08
`define ARX_VOTE_B_NORMAL 5'h09
`define ARX_VOTE_C_NORMAL 5'h0a
`define ARX_VOTE_A_DOUBLE 5'h04
`define ARX_VOTE_B_DOUBLE 5'h05
`define ARX_VOTE_C_DOUBLE 5'h06
`define ARX_SAMPLE_FIRST 5'h01
`define ARX_SAMPLE_SECOND 5'h02
`define ARX_BITS_MIN 4'h5
`define ARX_BITS_MAX 4'ha
`define ARX_DATA_W 10
`define ARX_CNT_W 5
`endif

// ==== include/arx_pkg.sv ====
// Types for the asynchronous receive recovery block.
// No assumptions beyond the defs header.
package arx_pkg;
    typedef enum logic [3:0] {
        ARX_IDLE = 4'b0001,
        ARX_START = 4'b0010,
        ARX_DATA = 4'b0100,
        ARX_STOP = 4'b1000
    } arx_state_t;
endpackage

// ==== hw/arx_async_rx.sv ====
// Receive clock and data recovery: start detection, majority voting, frame error.
// Assumes a one-cycle sampleTick from an outside baud generator at 16x or 8x.
`timescale 1ns/1ps
`include "arx_defs.svh"
module arx_async_rx
    import arx_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic sampleTick,
    input wire logic serialIn,
    input wire logic double_speed_select,
    input wire logic [3:0] frameBits,
    output logic [`ARX_DATA_W-1:0] rxData_reg,
    output logic frame_error_flag,
    output logic rxValid_reg,
    output logic busy_reg
);
    logic syncA_reg;
    logic syncB_reg;
    logic lineLast_reg;
    arx_state_t state_reg;
    logic [`ARX_CNT_W-1:0] phase_reg;
    logic [2:0] votes_reg;
    logic [3:0] bitIdx_reg;
    logic [3:0] bitsLatched_reg;
    logic [`ARX_DATA_W-1:0] shift_reg;
    logic [`ARX_CNT_W-1:0] spb;
    logic [`ARX_CNT_W-1:0] voteA;
    logic [`ARX_CNT_W-1:0] voteB;
    logic [`ARX_CNT_W-1:0] voteC;
    logic [3:0] bitsClamped;
    logic [2:0] votesNow;
    logic voted;
    logic atVoteEnd;
    logic atBitEnd;
    logic startEdge;
    logic frameDone;

    // Synchroniser; second stage feeds everything
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            syncA_reg <= 1'b1;
            syncB_reg <= 1'b1;
        end
        else
        begin
            syncA_reg <= serialIn;
            syncB_reg <= syncA_reg;
        end
    end

    // Edge detector; preset high so reset itself is no edge
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            lineLast_reg <= 1'b1;
        else if (sampleTick)
            lineLast_reg <= syncB_reg;
    end

    always_comb
    begin
        // Mode is a level; changing it mid-frame breaks that frame
        if (double_speed_select)
        begin
            spb = `ARX_SPB_DOUBLE;
            voteA = `ARX_VOTE_A_DOUBLE;
            voteB = `ARX_VOTE_B_DOUBLE;
            voteC = `ARX_VOTE_C_DOUBLE;
        end
        else
        begin
            spb = `ARX_SPB_NORMAL;
            voteA = `ARX_VOTE_A_NORMAL;
            voteB = `ARX_VOTE_B_NORMAL;
            voteC = `ARX_VOTE_C_NORMAL;
        end
        // Out-of-range sizes are clamped rather than rejected
        if (frameBits < `ARX_BITS_MIN)
            bitsClamped = `ARX_BITS_MIN;
        else if (frameBits > `ARX_BITS_MAX)
            bitsClamped = `ARX_BITS_MAX;
        else
            bitsClamped = frameBits;
        votesNow = votes_reg;
        if (phase_reg == voteA)
            votesNow[0] = syncB_reg;
        if (phase_reg == voteB)
            votesNow[1] = syncB_reg;
        if (phase_reg == voteC)
            votesNow[2] = syncB_reg;
        voted = (votesNow[0] & votesNow[1]) | (votesNow[0] & votesNow[2])
            | (votesNow[1] & votesNow[2]);
        atVoteEnd = (phase_reg == voteC);
        atBitEnd = (phase_reg == spb);
        startEdge = lineLast_reg && !syncB_reg;
        frameDone = sampleTick && (state_reg == ARX_STOP) && atVoteEnd;
    end

    // Sequencer; a tick-less cycle holds all state
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ARX_IDLE;
            phase_reg <= '0;
            votes_reg <= 3'h0;
            bitIdx_reg <= 4'h0;
            bitsLatched_reg <= `ARX_BITS_MIN;
            shift_reg <= '0;
        end
        else if (sampleTick)
        begin
            case (state_reg)
                ARX_IDLE:
                begin
                    if (startEdge)
                    begin
                        state_reg <= ARX_START;
                        // This tick took sample one, so the next one is sample two
                        phase_reg <= `ARX_SAMPLE_SECOND;
                        votes_reg <= 3'h0;
                        bitsLatched_reg <= bitsClamped;
                    end
                end
                ARX_START:
                begin
                    votes_reg <= votesNow;
                    phase_reg <= phase_reg + `ARX_SAMPLE_FIRST;
                    if (atVoteEnd)
                    begin
                        if (voted)
                            state_reg <= ARX_IDLE;
                    end
                    if (atBitEnd)
                    begin
                        state_reg <= ARX_DATA;
                        phase_reg <= `ARX_SAMPLE_FIRST;
                        bitIdx_reg <= 4'h0;
                        votes_reg <= 3'h0;
                    end
                end
                ARX_DATA:
                begin
                    votes_reg <= votesNow;
                    phase_reg <= phase_reg + `ARX_SAMPLE_FIRST;
                    if (atVoteEnd)
                        shift_reg <= {voted, shift_reg[`ARX_DATA_W-1:1]};
                    if (atBitEnd)
                    begin
                        phase_reg <= `ARX_SAMPLE_FIRST;
                        votes_reg <= 3'h0;
                        bitIdx_reg <= bitIdx_reg + 4'h1;
                        if (bitIdx_reg + 4'h1 == bitsLatched_reg)
                            state_reg <= ARX_STOP;
                    end
                end
                ARX_STOP:
                begin
                    votes_reg <= votesNow;
                    phase_reg <= phase_reg + `ARX_SAMPLE_FIRST;
                    // Back to idle at the last vote sample: no full stop bit wait
                    if (atVoteEnd)
                        state_reg <= ARX_IDLE;
                end
                default:
                    state_reg <= ARX_IDLE;
            endcase
        end
    end

    // Result; the data is right-aligned by the frame length
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rxData_reg <= '0;
            rxValid_reg <= 1'b0;
        end
        else
        begin
            rxValid_reg <= frameDone;
            if (frameDone)
                rxData_reg <= shift_reg >> (4'(`ARX_DATA_W) - bitsLatched_reg);
        end
    end

    // Flag stays with its frame until the next frame completes
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            frame_error_flag <= 1'b0;
        else if (frameDone)
            frame_error_flag <= ~voted;
    end

    // One cycle behind the state, so it comes straight from a flop
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            busy_reg <= 1'b0;
        else
            busy_reg <= (state_reg != ARX_IDLE);
    end
endmodule

// ==== verif/arx_rx_chk.sv ====
// Port checker for the receive recovery block.
// Assumes one clock and async active-low reset.
`timescale 1ns/1ps
module arx_rx_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sampleTick,
    input wire logic serialIn,
    input wire logic [3:0] frameBits,
    input wire logic [9:0] rxData_reg,
    input wire logic frame_error_flag,
    input wire logic rxValid_reg,
    input wire logic busy_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [3:0] hiCnt_reg;
    // Saturates so a long idle line stays visible
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            hiCnt_reg <= 4'h0;
        else if (!serialIn)
            hiCnt_reg <= 4'h0;
        else if (hiCnt_reg != 4'hf)
            hiCnt_reg <= hiCnt_reg + 4'h1;
    sequence sOpen; $rose(busy_reg); endsequence
    sequence sClose; ##[1:1000] !busy_reg; endsequence
    chk_valid_pulse: assert property (rxValid_reg |=> !rxValid_reg) else $error("valid too long");
    chk_data_hold: assert property (!rxValid_reg |-> $stable(rxData_reg)) else $error("data moved");
    chk_flag_hold: assert property (!rxValid_reg |-> $stable(frame_error_flag)) else $error("flag moved");
    chk_valid_tick: assert property (rxValid_reg |-> $past(sampleTick)) else $error("valid off tick");
    chk_busy_first: assert property (rxValid_reg |-> $past(busy_reg, 2)) else $error("valid unbusy");
    chk_quiet_line: assert property (hiCnt_reg == 4'hf && !busy_reg |=> !busy_reg) else $error("busy no edge");
    chk_frame_ends: assert property (sOpen |-> sClose) else $error("frame hung");
    chk_upper_zero: assert property (rxValid_reg && frameBits inside {[4'h5:4'ha]} |->
        (rxData_reg >> frameBits) == 10'h000) else $error("upper bits set");
endmodule
bind arx_async_rx arx_rx_chk u_arx_rx_chk (.clock(clock), .nrst(nrst), .sampleTick(sampleTick),
    .serialIn(serialIn), .frameBits(frameBits), .rxData_reg(rxData_reg),
    .frame_error_flag(frame_error_flag), .rxValid_reg(rxValid_reg), .busy_reg(busy_reg));

// ==== verif/arx_tx_model.sv ====
// Far-end serial transmitter model.
// Assumes the bench calls send; line idles high.
`timescale 1ns/1ps
module arx_tx_model (
    input wire logic clock,
    output logic serialOut
);
    initial serialOut = 1'b1;
    // Bit length in clocks sets the far rate, kept inside tolerance
    task automatic send(input int bitClks, input int nBits, input logic [9:0] data, input logic stopVal,
        input int stopClks);
        @(negedge clock);
        serialOut = 1'b0;
        repeat (bitClks) @(negedge clock);
        for (int k = 0; k < nBits; k++)
        begin
            serialOut = data[k];
            repeat (bitClks) @(negedge clock);
        end
        serialOut = stopVal;
        repeat (stopClks) @(negedge clock);
        serialOut = 1'b1;
    endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the receive recovery block.
// Assumes a sample tick every fourth clock from the bench.
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic dss; logic [3:0] n; logic [9:0] d; logic stop; logic [9:0] xd; logic xf;} arx_row_t;
    logic clock, nrst, dss, rxValid, busy, fe, got;
    logic sampleTick = 1'b0;
    logic [1:0] tickCnt = 2'h0;
    logic [3:0] frameBits;
    logic [9:0] rxData;
    wire serialIn;
    int error_cnt = 0;
    int num_checks = 0;
    arx_row_t rows [6] = '{'{1'b0, 4'h5, 10'h3f5, 1'b1, 10'h015, 1'b0}, '{1'b0, 4'h8, 10'h3a5, 1'b0, 10'h0a5, 1'b1},
        '{1'b0, 4'ha, 10'h3c3, 1'b1, 10'h3c3, 1'b0}, '{1'b1, 4'h6, 10'h2ed, 1'b1, 10'h02d, 1'b0},
        '{1'b1, 4'ha, 10'h1e7, 1'b0, 10'h1e7, 1'b1}, '{1'b1, 4'h9, 10'h35a, 1'b1, 10'h15a, 1'b0}};
    arx_async_rx u_arx_async_rx (.clock(clock), .nrst(nrst), .sampleTick(sampleTick), .serialIn(serialIn),
        .double_speed_select(dss), .frameBits(frameBits), .rxData_reg(rxData), .frame_error_flag(fe),
        .rxValid_reg(rxValid), .busy_reg(busy));
    arx_tx_model u_arx_tx_model (.clock(clock), .serialOut(serialIn));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(negedge clock)
    begin
        tickCnt <= tickCnt + 2'h1;
        sampleTick <= (tickCnt == 2'h3);
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Valid stands one cycle, so poll every clock
    task automatic wait_valid(input int lim);
        got = 1'b0;
        for (int k = 0; k < lim && got !== 1'b1; k++)
        begin
            @(negedge clock);
            got = rxValid;
        end
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        nrst = 1'b0;
        dss = 1'b0;
        frameBits = 4'h8;
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        foreach (rows[i])
        begin
            dss = rows[i].dss;
            frameBits = rows[i].n;
            repeat (8) @(negedge clock);
            fork
                u_arx_tx_model.send(dss ? 32 : 64, rows[i].n, rows[i].d, rows[i].stop, dss ? 32 : 64);
                wait_valid(1200);
            join
            check({9'h000, got}, 10'h001);
            check(rxData, rows[i].xd);
            check({9'h000, fe}, {9'h000, rows[i].xf});
        end
        // Out-of-range sizes: fifteen acts as ten, two as five
        dss = 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            frameBits = c[0] ? 4'h2 : 4'hf;
            repeat (8) @(negedge clock);
            fork
                u_arx_tx_model.send(64, c[0] ? 5 : 10, 10'h2b6, 1'b1, 64);
                wait_valid(1200);
            join
            check(rxData, c[0] ? 10'h016 : 10'h2b6);
        end
        for (int m = 0; m < 2; m++)
        begin
            dss = m[0];
            frameBits = 4'h5;
            u_arx_tx_model.send(dss ? 8 : 12, 0, 10'h000, 1'b1, 8);
            wait_valid(1000);
            check({9'h000, got}, 10'h000);
            // Low through sample 9 (5): only the first two votes see it
            fork
                u_arx_tx_model.send(dss ? 20 : 36, 0, 10'h000, 1'b1, 8);
                wait_valid(1000);
            join
            check({9'h000, got}, 10'h001);
            check(rxData, 10'h01f);
        end
        dss = 1'b0;
        frameBits = 4'h8;
        fork
            begin
                u_arx_tx_model.send(64, 8, 10'h0c3, 1'b1, 48);
                u_arx_tx_model.send(62, 8, 10'h03c, 1'b1, 200);
            end
            begin
                wait_valid(1000);
                check(rxData, 10'h0c3);
                wait_valid(1000);
                check(rxData, 10'h03c);
            end
        join
        fork
            u_arx_tx_model.send(64, 8, 10'h0ff, 1'b1, 64);
        join_none
        repeat (300) @(negedge clock);
        check({9'h000, busy}, 10'h001);
        nrst = 1'b0;
        @(negedge clock);
        check({8'h00, rxValid, busy}, 10'h000);
        nrst = 1'b1;
        wait fork;
        end_sim;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_sim;
    end
endmodule
